// *** rtl/flash_ctl_pkg.sv ***
// Constants, types and register map of the flash self-write controller
package flash_ctl_pkg;
    localparam logic [11:0] ctrl_offset    = 12'h000;
    localparam logic [11:0] key_offset     = 12'h004;
    localparam logic [11:0] page_offset    = 12'h008;
    localparam logic [11:0] ea_offset      = 12'h00c;
    localparam logic [11:0] tdata_offset   = 12'h010;
    localparam logic [11:0] status_offset  = 12'h014;
    localparam int          start_bit      = 15;
    localparam int          allow_bit      = 14;
    localparam int          err_bit        = 13;
    localparam int          erase_bit      = 6;
    localparam logic [15:0] ctrl_wmask     = 16'h604f;
    localparam logic [7:0]  key_first      = 8'h55;
    localparam logic [7:0]  key_second     = 8'haa;
    localparam int          row_words      = 64;
    localparam int          rows_per_page  = 8;
    localparam int          op_time_us     = 4000;
    localparam int          clk_mhz        = 200;
    localparam int          op_cycles      = op_time_us * clk_mhz;
    localparam int          twrite_cycles  = 2;
    localparam logic [3:0]  op_bulk        = 4'hf;
    localparam logic [3:0]  op_gen_seg     = 4'hd;
    localparam logic [3:0]  op_sec_seg     = 4'hc;
    localparam logic [3:0]  op_word        = 4'h3;
    localparam logic [3:0]  op_page        = 4'h2;
    localparam logic [3:0]  op_row         = 4'h1;
    localparam logic [3:0]  op_cfg         = 4'h0;
    // Table data register: bit 16 high byte (bits 23:16), bit 17 byte mode, bit 18 odd byte
    localparam int          tsel_high_bit  = 16;
    localparam int          tsel_byte_bit  = 17;
    localparam int          tsel_odd_bit   = 18;

    typedef enum logic [1:0] {
        key_idle  = 2'b00,
        key_half  = 2'b01,
        key_open  = 2'b11
    } key_state_t;

    typedef enum logic [3:0] {
        act_none, act_bulk, act_gen_seg, act_sec_seg,
        act_page, act_cfg_erase, act_word, act_row, act_cfg_prog
    } action_t;

    typedef struct packed {
        logic        erase;
        logic        config_space;
        action_t     action;
        logic [23:0] address;
    } flash_cmd_t;
endpackage

// *** rtl/flash_self_write.sv ***
// Flash self-write controller with APB registers and holding buffer
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flash_self_write
    import flash_ctl_pkg::*;
#(
    parameter int op_len = op_cycles                // Operation length in cycles
) (
    input  wire logic        pclk,                  // Clock, 200 MHz
    input  wire logic        presetn,               // Power-on reset, active low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB enable
    input  wire logic        pwrite,                // APB direction
    input  wire logic [11:0] paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    output logic             core_stall,            // Core held while busy
    output logic             flash_go,              // Command strobe to array
    output flash_cmd_t       flash_cmd,             // Command to array
    output logic [23:0]      row_word_low_addr      // Buffer row base address
);
    localparam int cnt_w = $clog2(op_len + 1);
    localparam logic [cnt_w-1:0] cnt_last = cnt_w'(op_len - 1);
    localparam logic [cnt_w-1:0] tw_last  = cnt_w'(twrite_cycles - 1);

    logic [15:0]      ctrl_q;
    logic [7:0]       page_q;
    logic [15:0]      ea_q;
    key_state_t       key_q;
    logic             busy_q;
    logic [cnt_w-1:0] cnt_q;
    logic             tw_busy_q;
    logic [cnt_w-1:0] tw_cnt_q;
    logic [23:0]      buf_mem [row_words];
    logic [5:0]       fill_q;

    logic setup;
    logic wr_acc;
    logic rd_acc;
    logic known;
    logic start_req;
    logic launch;
    logic [23:0] taddr;

    function automatic action_t decode(input logic erase, input logic [3:0] code);
        action_t a;
        a = act_none;
        if (erase) begin
            unique case (code)
                op_bulk:    a = act_bulk;
                op_gen_seg: a = act_gen_seg;
                op_sec_seg: a = act_sec_seg;
                op_page:    a = act_page;
                op_cfg:     a = act_cfg_erase;
                default:    a = act_none;
            endcase
        end else begin
            unique case (code)
                op_word: a = act_word;
                op_row:  a = act_row;
                op_cfg:  a = act_cfg_prog;
                default: a = act_none;
            endcase
        end
        return a;
    endfunction

    assign taddr = {page_q, ea_q};
    assign known = (paddr == ctrl_offset) || (paddr == key_offset) ||
                   (paddr == page_offset) || (paddr == ea_offset) ||
                   (paddr == tdata_offset) || (paddr == status_offset);
    // Table writes hold the bus for their fixed length
    assign setup  = psel && !penable;
    wire   tw_hit = psel && pwrite && paddr == tdata_offset;
    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_acc = psel && penable && !pwrite && pready;
    assign start_req = wr_acc && paddr == ctrl_offset && pwdata[start_bit] && !busy_q;
    assign launch    = start_req && key_q == key_open && pwdata[allow_bit];

    // Bus answer: one wait state for table data writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tw_busy_q <= 1'b0;
            tw_cnt_q  <= '0;
        end else if (setup && tw_hit) begin
            tw_busy_q <= 1'b1;
            tw_cnt_q  <= '0;
        end else if (tw_busy_q) begin
            tw_cnt_q <= tw_cnt_q + 1'b1;
            if (tw_cnt_q == tw_last - 1'b1)
                tw_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !pready && (tw_hit ? (tw_busy_q && tw_cnt_q == tw_last - 1'b1)
                                                  : penable || setup);
            pslverr <= psel && !pready && !known;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !pready) begin
            unique case (paddr)
                ctrl_offset:   prdata <= {16'h0000, ctrl_q};
                page_offset:   prdata <= {24'h000000, page_q};
                ea_offset:     prdata <= {16'h0000, ea_q};
                tdata_offset:  prdata <= {8'h00, buf_mem[ea_q[6:1]]};
                status_offset: prdata <= {26'h0, fill_q};
                default:       prdata <= '0;  // Key reads zero: write-only
            endcase
        end
    end

    // Unlock sequence tracker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            key_q <= key_idle;
        else if (wr_acc) begin
            if (paddr == key_offset && pwdata[7:0] == key_first)
                key_q <= key_half;
            else if (paddr == key_offset && key_q == key_half && pwdata[7:0] == key_second)
                key_q <= key_open;
            else
                key_q <= key_idle;
        end
    end

    // Control register; reset only by power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_q <= '0;
        else begin
            if (wr_acc && paddr == ctrl_offset && !busy_q) begin
                ctrl_q[allow_bit] <= pwdata[allow_bit];
                ctrl_q[erase_bit] <= pwdata[erase_bit];
                ctrl_q[3:0]       <= pwdata[3:0];
                ctrl_q[err_bit]   <= pwdata[err_bit];
            end
            if (start_req) begin
                if (key_q == key_open && pwdata[allow_bit]) begin
                    ctrl_q[start_bit] <= 1'b1;
                    ctrl_q[err_bit]   <= 1'b0;
                end else
                    ctrl_q[err_bit]   <= 1'b1;
            end else if (busy_q && cnt_q == cnt_last)
                ctrl_q[start_bit] <= 1'b0;
        end
    end

    // Self-timed operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q     <= 1'b0;
            cnt_q      <= '0;
            core_stall <= 1'b0;
            flash_go   <= 1'b0;
            flash_cmd  <= '0;
        end else begin
            flash_go <= 1'b0;
            if (start_req && key_q == key_open && pwdata[allow_bit]) begin
                busy_q     <= 1'b1;
                cnt_q      <= '0;
                core_stall <= 1'b1;
                flash_go   <= 1'b1;
                flash_cmd.erase        <= pwdata[erase_bit];
                flash_cmd.config_space <= page_q[7];
                flash_cmd.action       <= decode(pwdata[erase_bit], pwdata[3:0]);
                // Only a row program is row aligned; every other operation keeps the full address
                flash_cmd.address      <= (decode(pwdata[erase_bit], pwdata[3:0]) == act_row) ?
                                          {page_q, ea_q[15:7], 7'h00} : taddr;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 1'b1;
                if (cnt_q == cnt_last) begin
                    busy_q     <= 1'b0;
                    core_stall <= 1'b0;
                end
            end
        end
    end

    // Holding buffer fill; 64-word aligned group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_q            <= '0;
            row_word_low_addr <= '0;
        end else if (wr_acc && paddr == tdata_offset && !busy_q) begin
            row_word_low_addr <= {taddr[23:7], 7'h00};
            if (pwdata[tsel_high_bit])
                fill_q <= ea_q[6:1] + 6'h01;
        end else if (flash_go)
            fill_q <= '0;
    end

    always_ff @(posedge pclk) begin
        if (wr_acc && paddr == tdata_offset && !busy_q) begin
            if (pwdata[tsel_high_bit])
                buf_mem[ea_q[6:1]][23:16] <= pwdata[7:0];
            else if (pwdata[tsel_byte_bit] && pwdata[tsel_odd_bit])
                buf_mem[ea_q[6:1]][15:8] <= pwdata[7:0];
            else if (pwdata[tsel_byte_bit])
                buf_mem[ea_q[6:1]][7:0] <= pwdata[7:0];
            else
                buf_mem[ea_q[6:1]][15:0] <= pwdata[15:0];
        end
    end

    // Page and effective address registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= '0;
            ea_q   <= '0;
        end else if (wr_acc && paddr == page_offset)
            page_q <= pwdata[7:0];
        else if (wr_acc && paddr == ea_offset)
            ea_q <= pwdata[15:0];
    end

    property p_stall_span;
        @(posedge pclk) disable iff (!presetn)
        $rose(busy_q) |-> core_stall throughout (busy_q [*8]);
    endproperty
    a_stall_span: assert property (p_stall_span) else $error("stall dropped");

    property p_start_clears;
        @(posedge pclk) disable iff (!presetn)
        $fell(busy_q) |-> !ctrl_q[start_bit];
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start stuck");

    property p_locked_err;
        @(posedge pclk) disable iff (!presetn)
        (start_req && key_q != key_open) |=> ctrl_q[err_bit] && !busy_q;
    endproperty
    a_locked_err: assert property (p_locked_err) else $error("locked start ran");

    property p_allow_off;
        @(posedge pclk) disable iff (!presetn)
        (start_req && !pwdata[allow_bit]) |=> !flash_go;
    endproperty
    a_allow_off: assert property (p_allow_off) else $error("op ran without allow");

    property p_one_go;
        @(posedge pclk) disable iff (!presetn)
        flash_go |=> !flash_go;
    endproperty
    a_one_go: assert property (p_one_go) else $error("double commit");

    property p_unused_zero;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[12:7] == 6'h00 && ctrl_q[5:4] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("reserved bit set");

    property p_key_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == key_offset) |-> prdata == 32'h0;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero) else $error("key readable");

    property p_addr_form;
        @(posedge pclk) disable iff (!presetn)
        flash_go && flash_cmd.erase |-> flash_cmd.address == $past(taddr);
    endproperty
    a_addr_form: assert property (p_addr_form) else $error("bad address");

    sequence s_tw_setup;
        setup && tw_hit;
    endsequence

    sequence s_tw_answer;
        !pready ##1 pready;
    endsequence

    property p_tw_wait;
        @(posedge pclk) disable iff (!presetn)
        s_tw_setup |=> s_tw_answer;
    endproperty
    a_tw_wait: assert property (p_tw_wait) else $error("table write length");

    property p_launch;
        @(posedge pclk) disable iff (!presetn)
        launch |=> flash_go && busy_q && ctrl_q[start_bit] && !ctrl_q[err_bit];
    endproperty
    a_launch: assert property (p_launch) else $error("start not taken");

    property p_start_busy;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[start_bit] == busy_q;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start bit drift");

    property p_stall_busy;
        @(posedge pclk) disable iff (!presetn)
        core_stall == busy_q;
    endproperty
    a_stall_busy: assert property (p_stall_busy) else $error("stall mismatch");

    property p_op_len;
        @(posedge pclk) disable iff (!presetn)
        $fell(busy_q) |-> $past(cnt_q) == cnt_last;
    endproperty
    a_op_len: assert property (p_op_len) else $error("operation length");

    property p_key_first;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == key_offset && pwdata[7:0] == key_first) |=> key_q == key_half;
    endproperty
    a_key_first: assert property (p_key_first) else $error("first key lost");

    property p_key_second;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == key_offset && key_q == key_half && pwdata[7:0] == key_second)
            |=> key_q == key_open;
    endproperty
    a_key_second: assert property (p_key_second) else $error("second key lost");

    property p_key_drop;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr != key_offset) |=> key_q == key_idle;
    endproperty
    a_key_drop: assert property (p_key_drop) else $error("unlock kept");

    property p_go_keyed;
        @(posedge pclk) disable iff (!presetn)
        flash_go |-> $past(key_q) == key_open;
    endproperty
    a_go_keyed: assert property (p_go_keyed) else $error("go without unlock");

    property p_cfg_space;
        @(posedge pclk) disable iff (!presetn)
        flash_go |-> flash_cmd.config_space == $past(page_q[7]);
    endproperty
    a_cfg_space: assert property (p_cfg_space) else $error("space select");

    property p_erase_sel;
        @(posedge pclk) disable iff (!presetn)
        flash_go |-> flash_cmd.erase == ctrl_q[erase_bit];
    endproperty
    a_erase_sel: assert property (p_erase_sel) else $error("erase select");

    property p_row_base;
        @(posedge pclk) disable iff (!presetn)
        (flash_go && flash_cmd.action == act_row) |-> flash_cmd.address == {$past(taddr[23:7]), 7'h00};
    endproperty
    a_row_base: assert property (p_row_base) else $error("row base");

    property p_word_addr;
        @(posedge pclk) disable iff (!presetn)
        (flash_go && flash_cmd.action != act_row) |-> flash_cmd.address == $past(taddr);
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("word address");

    property p_prog_nop;
        @(posedge pclk) disable iff (!presetn)
        (launch && !pwdata[erase_bit] && pwdata[3:0] == op_bulk) |=> flash_cmd.action == act_none;
    endproperty
    a_prog_nop: assert property (p_prog_nop) else $error("program no-op");

    property p_erase_page;
        @(posedge pclk) disable iff (!presetn)
        (launch && pwdata[erase_bit] && pwdata[3:0] == op_page) |=> flash_cmd.action == act_page;
    endproperty
    a_erase_page: assert property (p_erase_page) else $error("page erase");

    property p_high_byte;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == tdata_offset && !busy_q && pwdata[tsel_high_bit])
            |=> buf_mem[ea_q[6:1]][23:16] == $past(pwdata[7:0]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte");

    property p_low_word;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == tdata_offset && !busy_q && !pwdata[tsel_high_bit] &&
         !pwdata[tsel_byte_bit]) |=> buf_mem[ea_q[6:1]][15:0] == $past(pwdata[15:0]);
    endproperty
    a_low_word: assert property (p_low_word) else $error("low word");
endmodule
`default_nettype wire

// *** bench/core_model.sv ***
// Processor core model: APB register traffic, unlock and start sequence
`timescale 1ns/1ps
`default_nettype none
module core_model
    import flash_ctl_pkg::*;
(
    input  wire logic        pclk,     // Clock
    input  wire logic        pready,   // APB ready
    input  wire logic        pslverr,  // APB error
    input  wire logic [31:0] prdata,   // APB read data
    output logic             psel,     // APB select
    output logic             penable,  // APB enable
    output logic             pwrite,   // APB direction
    output logic      [11:0] paddr,    // APB address
    output logic      [31:0] pwdata    // APB write data
);
    int waits;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // Request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        waits = 0;
        do begin
            @(posedge pclk);
            waits++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
        xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask

    // Setup, key pair, start, then two idle slots
    task automatic launch(input logic [15:0] v);
        wr(ctrl_offset, {16'h0000, v});
        wr(key_offset, {24'h000000, key_first});
        wr(key_offset, {24'h000000, key_second});
        wr(ctrl_offset, {16'h0000, v | 16'h8000});
        repeat (2) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench of the flash self-write controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    import flash_ctl_pkg::*;
    localparam int opl = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        core_stall, flash_go, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] row_word_low_addr;
    flash_cmd_t  flash_cmd;
    int          fail_count, checks_done, go_n, stall_n;

    flash_self_write #(.op_len(opl)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_stall(core_stall), .flash_go(flash_go),
        .flash_cmd(flash_cmd), .row_word_low_addr(row_word_low_addr));
    core_model i_core (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (flash_go === 1'b1) go_n++;
        if (core_stall === 1'b1) stall_n++;
    end

    task automatic finish_test;
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic t_reset_mask;
        i_core.rd(ctrl_offset, q, e);
        `CHK(q, 32'h0000_0000)
        i_core.rd(key_offset, q, e);
        `CHK(q, 32'h0000_0000)
        i_core.wr(ctrl_offset, 32'h0000_ffff);
        i_core.rd(ctrl_offset, q, e);
        `CHK(q, 32'h0000_604f)
        `CHK(go_n, 0)
        i_core.rd(12'h0fc, q, e);
        `CHK(e, 1'b1)
        `CHK(q, 32'h0000_0000)
        i_core.wr(ctrl_offset, 32'h0000_0000);
    endtask

    task automatic t_lock;
        i_core.wr(ctrl_offset, 32'h0000_4001);
        i_core.wr(key_offset, 32'h0000_0055);
        i_core.wr(page_offset, 32'h0000_0000);
        i_core.wr(key_offset, 32'h0000_00aa);
        i_core.wr(ctrl_offset, 32'h0000_c001);
        i_core.rd(ctrl_offset, q, e);
        `CHK(q, 32'h0000_6001)
        i_core.launch(16'h0001);
        i_core.rd(ctrl_offset, q, e);
        `CHK(q, 32'h0000_2001)
        `CHK(go_n, 0)
    endtask

    task automatic t_table;
        i_core.wr(page_offset, 32'h0000_0081);
        for (int i = 0; i < 2; i++) begin
            i_core.wr(ea_offset, 32'h0000_6000 + 2 * i);
            i_core.wr(tdata_offset, 32'h0000_1000 + i);
            `CHK(i_core.waits, 2)
            i_core.wr(tdata_offset, 32'h0001_0040 + i);
        end
        i_core.rd(tdata_offset, q, e);
        `CHK(q, 32'h0041_1001)
        `CHK(row_word_low_addr, 24'h81_6000)
        i_core.rd(status_offset, q, e);
        `CHK(q, 32'h0000_0002)
    endtask

    task automatic t_ops;
        logic [3:0]  code [9] = '{op_bulk, op_gen_seg, op_sec_seg, op_page, op_cfg,
                                  op_word, op_row, op_cfg, op_bulk};
        action_t     act [9] = '{act_bulk, act_gen_seg, act_sec_seg, act_page, act_cfg_erase,
                                 act_word, act_row, act_cfg_prog, act_none};
        logic [7:0]  pg;
        logic [15:0] v;
        int          g0;
        for (int i = 0; i < 9; i++) begin
            pg = i[0] ? 8'h82 : 8'h02;
            v = 16'h4000 | ((i < 5) ? 16'h0040 : 16'h0000) | {12'h000, code[i]};
            i_core.wr(page_offset, {24'h000000, pg});
            i_core.wr(ea_offset, 32'h0000_0c02);
            i_core.wr(ctrl_offset, 32'h0000_0000);
            g0 = go_n;
            stall_n = 0;
            i_core.launch(v);
            i_core.rd(ctrl_offset, q, e);
            `CHK(q, {16'h0000, v | 16'h8000})
            i_core.wr(ctrl_offset, 32'h0000_0000);
            for (int k = 0; k < 100 && core_stall !== 1'b0; k++) @(posedge pclk);
            `CHK(go_n, g0 + 1)
            `CHK(stall_n, opl)
            i_core.rd(status_offset, q, e);
            `CHK(q, 32'h0000_0000)
            i_core.rd(ctrl_offset, q, e);
            `CHK(q, {16'h0000, v})
            `CHK(flash_cmd.action, act[i])
            `CHK(flash_cmd.erase, v[6])
            `CHK(flash_cmd.config_space, pg[7])
            if (i != 6)
                `CHK(flash_cmd.address, {pg, 16'h0c02})
            if (i == 6)
                `CHK(flash_cmd.address, {pg, 16'h0c00})
        end
    endtask

    initial begin
        presetn = 1'b0;
        fail_count = 0;
        checks_done = 0;
        go_n = 0;
        stall_n = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_mask();
        t_lock();
        t_table();
        t_ops();
        finish_test();
    end

    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
